/* File: pkg/power_save_defs.svh */
`ifndef POWER_SAVE_DEFS_SVH
`define POWER_SAVE_DEFS_SVH

// Register word offsets (byte addresses on the Avalon bus)
`define OFS_CLOCK_DIVIDER 4'h0
`define OFS_GATE_ONE 4'h4
`define OFS_STATUS 4'h8
`define OFS_POWER_CTRL 4'hC

// Clock divider register fields
`define DIV_ROI_BIT 15
`define DIV_RATIO_HI 14
`define DIV_RATIO_LO 12
`define DIV_DOZE_BIT 11
`define DIV_WRITE_MASK 16'hF800
`define DIV_RESET 16'h0000

// Gate register: bits 10-9 unimplemented
`define GATE_IMPL_MASK 16'hF9FF
`define GATE_RESET 16'h0000

// Power control command codes in the low bits
`define CMD_SLEEP 2'h1
`define CMD_IDLE 2'h2

// Gate change delay in instruction cycles
`define GATE_DELAY_CYC 1

`endif

/* File: pkg/power_save_pkg.sv */
package power_save_pkg;
	typedef enum logic [1:0] {
		PS_RUN,
		PS_SLEEP,
		PS_IDLE
	} ps_state_t;

	// Wake sources, grouped
	typedef struct packed {
		logic irq;
		logic watchdogTimeout;
		logic devReset;
	} wake_src_t;

	// Clock enables and the watchdog clear that leave the block
	typedef struct packed {
		logic sysClkSrcEn;
		logic cpuClkEn;
		logic periphClkEn;
		logic lprcEn;
		logic failMonEn;
		logic watchdogClear;
	} clk_ctrl_t;
endpackage

/* File: hw/doze_divider.sv */
`timescale 1ns/1ps
`include "power_save_defs.svh"
module doze_divider
	import power_save_pkg::*;
#(
	parameter int RATIO_W = 3
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Control
	input wire logic dozeOn,
	input wire logic [RATIO_W-1:0] ratio,
	// Output tick
	output logic tick
);
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic [7:0] lastCount;
	logic wrapNow;

	// Divisor 2**ratio, count to divisor-1
	assign lastCount = 8'(({1'b0, 8'h01} << ratio) - 9'h001);
	assign wrapNow = (cnt_reg >= lastCount);
	assign cnt_next = (!dozeOn || wrapNow) ? 8'h00 : 8'(cnt_reg + 8'h01);
	// One CPU tick per divisor cycles; free-running 1:1 outside doze
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 8'h00;
			tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_next;
			tick <= !dozeOn || wrapNow;
		end
	end
endmodule

/* File: hw/power_save_clock_gating.sv */
// Notes on behaviour
// - Sleep operand stops clocks and execution
// - Idle operand stops CPU, peripherals run
// - Wake on enabled irq, reset, watchdog
// - Sleep shuts down system clock source
// - Clock-fail monitor off during sleep
// - Sleep keeps RC running if watchdog on
// - Watchdog cleared entering sleep or idle
// - Sleep disables system-clocked peripherals
// - Wake from sleep keeps same source
// - Idle keeps source, gated peripherals stop
// - Idle keeps RC if watchdog/monitor on
// - Idle wake restores CPU clock immediately
// - Coincident interrupt deferred until entry
// - Doze slows only CPU clock
// - Doze enable at divider bit 11
// - Ratio bits 14:12, default 1:1
// - Bit 15 lets interrupt end doze
// - Gate bit stops peripheral clocks
// - Gated peripheral registers ignore access
// - Enabled only if ungated and present
// - Gate change takes one instruction cycle
// - Gate register bit map
//
// Local design decisions: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "power_save_defs.svh"
module power_save_clock_gating
	import power_save_pkg::*;
#(
	parameter logic [15:0] PRESENT_MASK = 16'hF9FF
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// CPU power-save instruction
	input wire logic saveReq,
	input wire logic saveIsSleep,
	// Wake sources and enables, from other logic on clk_sys
	input wire wake_src_t wakeSrc,
	input wire logic watchdogEnabled,
	input wire logic failMonEnabled,
	// Clock controls
	output clk_ctrl_t clkCtrl,
	output logic cpuTick,
	output logic [15:0] periphEnable,
	output logic [15:0] periphRegAccessOk
);
	ps_state_t state_reg;
	ps_state_t state_next;
	logic [15:0] div_reg;
	logic [15:0] gate_reg;
	logic [15:0] gateDly_reg;
	logic [15:0] gateWrite;
	logic [15:0] divWrite;
	logic doze_reg;
	logic pendIrq_reg;
	logic ack_reg;
	logic [31:0] rdMux;
	logic selDiv;
	logic selGate;
	logic selStat;
	logic selCtrl;
	logic access;
	logic wrDiv;
	logic wrGate;
	logic wrCtrl;
	logic wakeAny;
	logic enterSleep;
	logic enterIdle;
	logic divTick;
	logic rawTick;
	logic [1:0] swCmd;
	logic wrTake;
	logic nextRun;
	logic nextSleep;
	logic sysSrcNext;
	logic cpuEnNext;
	logic periphClkNext;
	logic failMonNext;
	logic lprcNext;
	logic wdClearNext;
	logic [15:0] periphEnNext;
	logic [15:0] accessOkNext;
	logic [31:0] statusWord;

	// Address decode; unmapped reads give zero, writes are dropped
	assign selDiv = (address == `OFS_CLOCK_DIVIDER);
	assign selGate = (address == `OFS_GATE_ONE);
	assign selStat = (address == `OFS_STATUS);
	assign selCtrl = (address == `OFS_POWER_CTRL);
	assign access = (read || write) && !ack_reg;

	// Writes land on the acknowledge edge, where the master sees waitrequest low
	// Landing earlier would let a master that aborts still change state
	assign wrTake = write && ack_reg;
	assign wrDiv = wrTake && selDiv;
	assign wrGate = wrTake && selGate;
	// Command byte must be enabled, else a partial write could trigger sleep
	assign wrCtrl = wrTake && selCtrl && byteenable[0];

	// Byte-lane merge for 16-bit registers
	assign divWrite = {byteenable[1] ? writedata[15:8] : div_reg[15:8],
		byteenable[0] ? writedata[7:0] : div_reg[7:0]} & `DIV_WRITE_MASK;
	assign gateWrite = {byteenable[1] ? writedata[15:8] : gate_reg[15:8],
		byteenable[0] ? writedata[7:0] : gate_reg[7:0]} & `GATE_IMPL_MASK;

	// Status word: pending wake, doze, idle, sleep, peripheral 0 running
	assign statusWord = {27'h0000000, pendIrq_reg, doze_reg, (state_reg == PS_IDLE),
		(state_reg == PS_SLEEP), periphEnable[0]};

	// Read select; upper half of every register reads zero
	assign rdMux = selDiv ? {16'h0000, div_reg} :
		selGate ? {16'h0000, gate_reg} :
		selStat ? statusWord :
		32'h00000000;

	// Software command or CPU pin may request power save
	assign swCmd = writedata[1:0];
	assign enterSleep = state_reg == PS_RUN &&
		((saveReq && saveIsSleep) || (wrCtrl && swCmd == `CMD_SLEEP));
	assign enterIdle = state_reg == PS_RUN &&
		((saveReq && !saveIsSleep) || (wrCtrl && swCmd == `CMD_IDLE));

	// Any enabled interrupt, reset or watchdog time-out wakes
	assign wakeAny = wakeSrc.irq || wakeSrc.watchdogTimeout || wakeSrc.devReset;

	// Mode sequencer; entry always completes before a wake is honoured
	// Requests made outside run are ignored, so a late command cannot stack
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			PS_RUN: begin
				if (enterSleep) begin
					state_next = PS_SLEEP;
				end else if (enterIdle) begin
					state_next = PS_IDLE;
				end
			end
			PS_SLEEP, PS_IDLE: begin
				if (wakeAny || pendIrq_reg) begin
					state_next = PS_RUN;
				end
			end
			default: begin
				state_next = PS_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= PS_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// Interrupt coinciding with entry is held, then wakes next cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pendIrq_reg <= 1'b0;
		end else if (enterSleep || enterIdle) begin
			pendIrq_reg <= wakeAny;
		end else begin
			pendIrq_reg <= 1'b0;
		end
	end

	// Bus handshake: one wait cycle then acknowledge
	// Read data is captured on the take edge and stands on the acknowledge edge
	// The set ack blocks a second take, giving one idle cycle between accesses
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
			waitrequest <= 1'b1;
			readdata <= 32'h00000000;
		end else begin
			ack_reg <= access;
			waitrequest <= !access;
			if (access && read) begin
				readdata <= rdMux;
			end
		end
	end

	// Divider register; interrupt clears doze when return-on-interrupt set
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= `DIV_RESET;
		end else if (div_reg[`DIV_ROI_BIT] && wakeSrc.irq) begin
			div_reg[`DIV_DOZE_BIT] <= 1'b0;
		end else if (wrDiv) begin
			div_reg <= divWrite;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			doze_reg <= 1'b0;
		end else begin
			doze_reg <= div_reg[`DIV_DOZE_BIT];
		end
	end

	// Gate register and its one-cycle delayed copy
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gate_reg <= `GATE_RESET;
			gateDly_reg <= `GATE_RESET;
		end else begin
			if (wrGate) begin
				gate_reg <= gateWrite;
			end
			gateDly_reg <= gate_reg;
		end
	end

	// CPU tick divider; only CPU is slowed, peripherals stay full rate
	doze_divider #(
		.RATIO_W(3)
	) u_doze (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.dozeOn(doze_reg),
		.ratio(div_reg[`DIV_RATIO_HI:`DIV_RATIO_LO]),
		.tick(rawTick)
	);

	// Mode of the coming cycle, shared by every clock enable and the CPU tick
	// Using the next state lets outputs switch on the entry edge itself
	assign nextRun = (state_next == PS_RUN);
	assign nextSleep = (state_next == PS_SLEEP);

	// CPU ticks only in run; doze thins them, peripherals are untouched
	assign divTick = rawTick && nextRun;

	// Source stays selected; only its enable drops in sleep
	assign sysSrcNext = !nextSleep;
	assign cpuEnNext = nextRun;
	assign periphClkNext = !nextSleep;

	// Monitor has nothing to watch once the source is stopped
	assign failMonNext = failMonEnabled && !nextSleep;

	// In sleep only the watchdog keeps the RC oscillator alive
	assign lprcNext = nextSleep ? watchdogEnabled :
		(watchdogEnabled || failMonEnabled);

	// One-cycle clear as sleep or idle is entered
	assign wdClearNext = watchdogEnabled && (enterSleep || enterIdle);

	// Present and ungated, and not starved by sleep; uses the delayed gate copy
	assign periphEnNext = ~gateDly_reg & PRESENT_MASK &
		{16{!nextSleep}};

	// Register access follows the gate and presence only, not sleep, so software can ungate in idle
	assign accessOkNext = ~gateDly_reg & PRESENT_MASK;

	// Clock controls, registered so no enable glitches downstream
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			clkCtrl <= '{sysClkSrcEn: 1'b1, cpuClkEn: 1'b1, periphClkEn: 1'b1,
				lprcEn: 1'b0, failMonEn: 1'b0, watchdogClear: 1'b0};
		end else begin
			clkCtrl <= '{sysClkSrcEn: sysSrcNext, cpuClkEn: cpuEnNext, periphClkEn: periphClkNext,
				lprcEn: lprcNext, failMonEn: failMonNext, watchdogClear: wdClearNext};
		end
	end

	// CPU tick; held low in reset so no instruction runs early
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cpuTick <= 1'b0;
		end else begin
			cpuTick <= divTick;
		end
	end

	// Peripheral enables and register access, off until reset is released
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			periphEnable <= 16'h0000;
			periphRegAccessOk <= 16'h0000;
		end else begin
			periphEnable <= periphEnNext;
			periphRegAccessOk <= accessOkNext;
		end
	end
endmodule

/* File: verif/power_save_clock_gating_chk.sv */
`timescale 1ns/1ps
module power_save_clock_gating_chk
	import power_save_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Requests and wake
	input wire logic saveReq,
	input wire logic saveIsSleep,
	input wire wake_src_t wakeSrc,
	input wire logic watchdogEnabled,
	input wire logic failMonEnabled,
	// Watched outputs
	input wire clk_ctrl_t clkCtrl,
	input wire logic [15:0] periphEnable
);
	// One domain, so clock and reset are given once
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	property p_sleep;
		saveReq && saveIsSleep && clkCtrl.cpuClkEn |=> !clkCtrl.cpuClkEn && !clkCtrl.sysClkSrcEn;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep entry");
	property p_idle;
		saveReq && !saveIsSleep && clkCtrl.cpuClkEn |=> !clkCtrl.cpuClkEn && clkCtrl.sysClkSrcEn && clkCtrl.periphClkEn;
	endproperty
	a_idle: assert property (p_idle) else $error("idle entry");
	property p_fm;
		!clkCtrl.sysClkSrcEn |-> !clkCtrl.failMonEn;
	endproperty
	a_fm: assert property (p_fm) else $error("monitor in sleep");
	property p_rc;
		!clkCtrl.sysClkSrcEn && $past(watchdogEnabled) |-> clkCtrl.lprcEn;
	endproperty
	a_rc: assert property (p_rc) else $error("rc off in sleep");
	property p_wdc;
		saveReq && clkCtrl.cpuClkEn && watchdogEnabled |=> clkCtrl.watchdogClear;
	endproperty
	a_wdc: assert property (p_wdc) else $error("no watchdog clear");
	property p_pslp;
		!clkCtrl.sysClkSrcEn && !$past(clkCtrl.sysClkSrcEn) |-> periphEnable == 16'h0000;
	endproperty
	a_pslp: assert property (p_pslp) else $error("periph on in sleep");
	property p_wake;
		!clkCtrl.cpuClkEn && (|wakeSrc) |=> clkCtrl.cpuClkEn;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");
	property p_coin;
		saveReq && clkCtrl.cpuClkEn && wakeSrc.irq |=> !clkCtrl.cpuClkEn ##1 clkCtrl.cpuClkEn;
	endproperty
	a_coin: assert property (p_coin) else $error("coincident irq");
endmodule

/* File: verif/cpu_side_model.sv */
`timescale 1ns/1ps
module cpu_side_model
	import power_save_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Bench commands
	input wire logic go,
	input wire logic goSleep,
	input wire logic [3:0] wakeDelay,
	input wire logic [1:0] wakeKind,
	// To the block
	output logic saveReq = 1'b0,
	output logic saveIsSleep = 1'b0,
	output wake_src_t wakeSrc = 3'h0
);
	int cnt = 0;
	// One-cycle instruction, wake a set time later; delay 0 lands with it
	always @(posedge clk_sys) begin
		saveReq <= go;
		saveIsSleep <= goSleep;
		cnt <= go ? int'(wakeDelay) : cnt - 1;
		wakeSrc <= ((go && wakeDelay == 4'h0) || (!go && cnt == 1)) ? wake_src_t'(3'h4 >> wakeKind) : 3'h0;
	end
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`include "power_save_defs.svh"
module testbench;
	import power_save_pkg::*;
	localparam logic [15:0] PM = 16'h79FF;
	logic clk_sys = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, go = 1'b0, goSleep = 1'b0;
	logic watchdogEnabled = 1'b0, failMonEnabled = 1'b0, waitrequest, saveReq, saveIsSleep, cpuTick;
	logic [3:0] address = 4'h0, wakeDelay = 4'h0;
	logic [1:0] wakeKind = 2'h0;
	logic [31:0] writedata = 32'h0, readdata, q;
	logic [15:0] periphEnable, periphRegAccessOk, v;
	wake_src_t wakeSrc;
	clk_ctrl_t clkCtrl;
	int n_errors = 0, checked = 0, n, d;
	// Clock
	always #5 clk_sys = ~clk_sys;
	// Block with one peripheral absent; byte lanes all on
	power_save_clock_gating #(.PRESENT_MASK(PM)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
		.waitrequest(waitrequest), .saveReq(saveReq), .saveIsSleep(saveIsSleep), .wakeSrc(wakeSrc),
		.watchdogEnabled(watchdogEnabled), .failMonEnabled(failMonEnabled), .clkCtrl(clkCtrl),
		.cpuTick(cpuTick), .periphEnable(periphEnable), .periphRegAccessOk(periphRegAccessOk));
	cpu_side_model u_cpu (.clk_sys(clk_sys), .go(go), .goSleep(goSleep), .wakeDelay(wakeDelay),
		.wakeKind(wakeKind), .saveReq(saveReq), .saveIsSleep(saveIsSleep), .wakeSrc(wakeSrc));
	// Enabled set expected for a gate value
	function automatic logic [15:0] gate_exp(input logic [15:0] g);
		return PM & ~g;
	endfunction
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	// Avalon access held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] dw, output logic [31:0] dr);
		int w;
		w = 0;
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= dw;
		do begin
			@(posedge clk_sys);
			w++;
		end while (waitrequest !== 1'b0 && w < 50);
		dr = readdata;
		read <= 1'b0;
		write <= 1'b0;
		chk("bus ack", 1, w < 50);
		@(posedge clk_sys);
	endtask
	// One power-save episode; wake seen dl+3 edges on, or 4 when coincident
	task automatic nap(input logic sl, input int dl, input logic [1:0] k);
		go <= 1'b1;
		goSleep <= sl;
		wakeDelay <= 4'(dl);
		wakeKind <= k;
		n = 0;
		do begin
			@(posedge clk_sys);
			go <= 1'b0;
			n++;
			if (n == 3) begin
				chk("cpuClkEn", 0, clkCtrl.cpuClkEn);
				chk("sysClkSrcEn", !sl, clkCtrl.sysClkSrcEn);
			end
		end while ((n < 3 || clkCtrl.cpuClkEn !== 1'b1) && n < 40);
		chk("wake cycles", dl == 0 ? 4 : dl + 3, n);
		@(posedge clk_sys);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Hang guard, well above the few thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		wrap_up;
	end
	// Main sequence
	initial begin
		void'($urandom(32'hD8A93B91));
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk("rst periph", PM, periphEnable);
		bus(0, `OFS_GATE_ONE, 32'h0, q);
		chk("rst gate", 0, q);
		bus(0, `OFS_CLOCK_DIVIDER, 32'h0, q);
		chk("rst divider", 0, q);
		bus(0, 4'h2, 32'h0, q);
		chk("unmapped", 0, q);
		$display("done reset");
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 16'hFFFF : (i == 5) ? 16'h0000 : 16'($urandom);
			bus(1, `OFS_GATE_ONE, 32'(v), q);
			bus(0, `OFS_GATE_ONE, 32'h0, q);
			chk("gate rd", v & `GATE_IMPL_MASK, q);
			chk("periphEnable", gate_exp(v), periphEnable);
			chk("accessOk", gate_exp(v), periphRegAccessOk);
		end
		$display("done gate");
		for (int r = 0; r < 9; r++) begin
			v = (r < 8) ? 16'h0800 | 16'(r << 12) : 16'h7000;
			bus(1, `OFS_CLOCK_DIVIDER, 32'(v), q);
			bus(0, `OFS_CLOCK_DIVIDER, 32'h0, q);
			chk("divider", 32'(v), q);
			d = 0;
			repeat (256) begin
				@(posedge clk_sys);
				d += int'(cpuTick);
			end
			chk("ticks", r < 8 ? 256 >> r : 256, d);
		end
		$display("done doze");
		for (int r = 0; r < 2; r++) begin
			bus(1, `OFS_CLOCK_DIVIDER, r ? 32'h9800 : 32'h1800, q);
			nap(1'b0, 5, 2'h0);
			bus(0, `OFS_CLOCK_DIVIDER, 32'h0, q);
			chk("roi", r ? 32'h9000 : 32'h1800, q);
		end
		bus(1, `OFS_CLOCK_DIVIDER, 32'h0, q);
		$display("done roi");
		bus(1, `OFS_POWER_CTRL, 32'(`CMD_IDLE), q);
		chk("sw idle cpu", 0, clkCtrl.cpuClkEn);
		bus(0, `OFS_STATUS, 32'h0, q);
		chk("status idle", 32'h5, q);
		go <= 1'b1;
		goSleep <= 1'b0;
		wakeDelay <= 4'h0;
		wakeKind <= 2'h0;
		repeat (4) @(posedge clk_sys) go <= 1'b0;
		bus(0, `OFS_STATUS, 32'h0, q);
		chk("status run", 32'h1, q);
		$display("done sw idle");
		for (int i = 0; i < 10; i++) begin
			d = (i < 2) ? i : $urandom_range(10);
			watchdogEnabled <= 1'($urandom);
			failMonEnabled <= 1'($urandom);
			@(posedge clk_sys);
			nap(1'(i), d, d == 0 ? 2'h0 : 2'($urandom_range(2)));
		end
		$display("done naps");
		wrap_up;
	end
endmodule
bind power_save_clock_gating power_save_clock_gating_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.saveReq(saveReq), .saveIsSleep(saveIsSleep), .wakeSrc(wakeSrc), .watchdogEnabled(watchdogEnabled),
	.failMonEnabled(failMonEnabled), .clkCtrl(clkCtrl), .periphEnable(periphEnable));
